// >>> verilog/sy_pll_pkg.sv
// Constants and state types for the synthesizer control-word block.
package sy_pll_pkg;

   // ---------------------------------------------------------------
   // Serial word and register select codes.
   // ---------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam logic [2:0] SEL_FREQ = 3'h0;
   localparam logic [2:0] SEL_MOD = 3'h1;
   localparam logic [2:0] SEL_REF = 3'h2;
   localparam int SEL_MSB = 2;

   // ---------------------------------------------------------------
   // Frequency word fields.
   // ---------------------------------------------------------------
   localparam int FRACTION_NUMERATOR_LSB = 3;
   localparam int FRACTION_NUMERATOR_MSB = 14;
   localparam int INT_LSB = 15;
   localparam int INT_MSB = 30;

   // ---------------------------------------------------------------
   // Modulus, phase and prescaler word fields.
   // ---------------------------------------------------------------
   localparam int MODU_LSB = 3;
   localparam int MODU_MSB = 14;
   localparam int PHASE_LSB = 15;
   localparam int PHASE_MSB = 26;
   localparam int PRESC_BIT = 27;
   localparam int PHADJ_BIT = 28;

   // ---------------------------------------------------------------
   // Reference, lock-detect and charge-pump word fields.
   // ---------------------------------------------------------------
   localparam int CNTRST_BIT = 3;
   localparam int PUMP3S_BIT = 4;
   localparam int SHDN_BIT = 5;
   localparam int POL_BIT = 6;
   localparam int LWIN_BIT = 7;
   localparam int LCNT_BIT = 8;
   localparam int PUMP_LSB = 9;
   localparam int PUMP_MSB = 12;
   localparam int DBUF_BIT = 13;
   localparam int RDIV_LSB = 14;
   localparam int RDIV_MSB = 23;
   localparam int HALVE_BIT = 24;
   localparam int DBL_BIT = 25;
   localparam int TMUX_LSB = 26;
   localparam int TMUX_MSB = 28;
   localparam int NOISE_LSB = 29;
   localparam int NOISE_MSB = 30;

   // ---------------------------------------------------------------
   // Reset values, lock detect and resync figures.
   // ---------------------------------------------------------------
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [5:0] LOCK_CYC_SLOW = 6'h28;
   localparam logic [5:0] LOCK_CYC_FAST = 6'h05;
   localparam int LOCK_WIN_WIDE_NS = 10;
   localparam int LOCK_WIN_NARROW_NS = 6;
   localparam logic [1:0] RESYNC_MODE_PHASE = 2'h2;

   // ---------------------------------------------------------------
   // State of the system clock domain.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic le_s1;
      logic le_s2;
      logic le_s3;
      logic ref_s1;
      logic ref_s2;
      logic ref_s3;
      logic wwide_s1;
      logic wwide_s2;
      logic wnar_s1;
      logic wnar_s2;
      logic [31:0] freq_word;
      logic [31:0] mod_word;
      logic [31:0] ref_word;
      logic [11:0] modulus_act;
      logic [11:0] phase_act;
      logic dbl_act;
      logic halve_act;
      logic [9:0] rdiv_act;
      logic [3:0] pump_act;
      logic [2:0] outdiv_act;
      logic [9:0] rcnt;
      logic tog;
      logic pfd_out;
      logic [5:0] lock_cnt;
      logic lock;
      logic commit;
      logic band_go;
      logic resync_go;
   } sy_sys_type;

   // ---------------------------------------------------------------
   // State of the serial link clock domain.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] shift;
   } sy_link_type;

endpackage

// >>> verilog/sy_pll_regs.sv
// Control-word decode, double buffering, reference path and lock detect.
`timescale 1ns/1ps
module sy_pll_regs
   import sy_pll_pkg::*;
#(
   parameter logic [1:0] NOISE_LOW_SPUR = 2'h3
) (
   // System clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Three-wire serial link.
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_ser_le,
   // Reference input and lock window comparators.
   input wire logic i_ref_in,
   input wire logic i_err_in_wide,
   input wire logic i_err_in_narrow,
   // Fields held by neighbouring register logic.
   input wire logic [1:0] i_resync_mode,
   input wire logic [2:0] i_out_div_sel,
   // Frequency word fields and commit pulses.
   output logic [15:0] o_integer_value,
   output logic [11:0] o_fraction_numerator,
   output logic o_freq_commit,
   output logic o_band_select_start,
   output logic o_resync_start,
   // Modulus word fields.
   output logic [11:0] o_fractional_modulus,
   output logic [11:0] o_phase_word,
   output logic o_prescaler_select,
   output logic o_phase_adjust_enable,
   // Reference and pump controls.
   output logic [1:0] o_noise_mode,
   output logic o_dither_enable,
   output logic [2:0] o_test_mux_output,
   output logic o_ref_doubler,
   output logic o_reference_halve,
   output logic [9:0] o_ref_count,
   output logic [3:0] o_pump_current,
   output logic o_pd_polarity,
   output logic o_pump_tristate,
   output logic o_counters_held,
   output logic o_vco_power_down,
   output logic o_outputs_enable,
   output logic [2:0] o_out_div_active,
   output logic o_lock_cycle_count_select,
   output logic o_lock_window_select,
   output logic o_software_shutdown,
   // Detector reference and lock.
   output logic o_pfd_ref,
   output logic o_digital_lock
);

   // ---------------------------------------------------------------
   // Link domain: serial shift register.
   // ---------------------------------------------------------------
   sy_link_type lk_reg;
   sy_link_type lk_next;

   // Bits enter at the bottom so the first bit sent ends up as bit 31.
   always_comb begin
      lk_next = lk_reg;
      if (!i_ser_le) begin
         lk_next.shift = {lk_reg.shift[30:0], i_ser_data};
      end
   end

   // The host stops its clock while load-enable is high, so the word
   // stays still for the system domain to copy.
   always_ff @(posedge i_ser_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lk_reg <= '0;
      end else begin
         lk_reg <= lk_next;
      end
   end

   // ---------------------------------------------------------------
   // System domain state.
   // ---------------------------------------------------------------
   sy_sys_type st_reg;
   sy_sys_type st_next;
   logic load_evt;
   logic [2:0] load_sel;
   logic ref_edge;
   logic hold_cnt;
   logic div_pulse;
   logic pfd_tick;
   logic in_window;
   logic [5:0] lock_need;
   logic [9:0] rdiv_eff;

   // Counter steps; the compare and the update share one adder so they agree.
   function automatic logic [9:0] ref_step(input logic [9:0] cnt);
      return cnt + 10'h001;
   endfunction

   function automatic logic [5:0] lock_step(input logic [5:0] cnt);
      return cnt + 6'h01;
   endfunction

   // Load-enable rise is seen only after two synchroniser stages.
   assign load_evt = st_reg.le_s2 & ~st_reg.le_s3;
   assign load_sel = lk_reg.shift[SEL_MSB:0];

   // Without the doubler only the falling edge counts; with it both do.
   assign ref_edge = st_reg.dbl_act ? (st_reg.ref_s2 ^ st_reg.ref_s3) :
      (~st_reg.ref_s2 & st_reg.ref_s3);

   // Counter reset and shutdown both park the counters.
   assign hold_cnt = st_reg.ref_word[CNTRST_BIT] | st_reg.ref_word[SHDN_BIT];

   // A ratio of zero is illegal; treating it as one keeps the path alive.
   assign rdiv_eff = (st_reg.rdiv_act == 10'h000) ? 10'h001 : st_reg.rdiv_act;
   assign div_pulse = ref_edge & (ref_step(st_reg.rcnt) >= rdiv_eff);

   // With the halving stage a detector cycle is two divider periods.
   assign pfd_tick = div_pulse & (~st_reg.halve_act | st_reg.tog);

   // Window comparator chosen by the precision bit.
   assign in_window = st_reg.ref_word[LWIN_BIT] ? st_reg.wnar_s2 :
      st_reg.wwide_s2;
   assign lock_need = st_reg.ref_word[LCNT_BIT] ? LOCK_CYC_FAST : LOCK_CYC_SLOW;

   // Next-state logic for the whole system domain.
   always_comb begin
      st_next = st_reg;
      // Pins pass two flops first; the third stage only serves edge detection.
      st_next.le_s1 = i_ser_le;
      st_next.le_s2 = st_reg.le_s1;
      st_next.le_s3 = st_reg.le_s2;
      st_next.ref_s1 = i_ref_in;
      st_next.ref_s2 = st_reg.ref_s1;
      st_next.ref_s3 = st_reg.ref_s2;
      st_next.wwide_s1 = i_err_in_wide;
      st_next.wwide_s2 = st_reg.wwide_s1;
      st_next.wnar_s1 = i_err_in_narrow;
      st_next.wnar_s2 = st_reg.wnar_s1;
      st_next.commit = 1'b0;
      st_next.band_go = 1'b0;
      st_next.resync_go = 1'b0;

      // Word transfer by select code; other codes belong elsewhere.
      if (load_evt) begin
         if (load_sel == SEL_FREQ) begin
            st_next.freq_word = lk_reg.shift;
            st_next.commit = 1'b1;
            // Buffered fields move to the active copies together.
            st_next.modulus_act = st_reg.mod_word[MODU_MSB:MODU_LSB];
            st_next.phase_act = st_reg.mod_word[PHASE_MSB:PHASE_LSB];
            st_next.dbl_act = st_reg.ref_word[DBL_BIT];
            st_next.halve_act = st_reg.ref_word[HALVE_BIT];
            st_next.rdiv_act = st_reg.ref_word[RDIV_MSB:RDIV_LSB];
            st_next.pump_act = st_reg.ref_word[PUMP_MSB:PUMP_LSB];
            if (st_reg.ref_word[DBUF_BIT]) begin
               st_next.outdiv_act = i_out_div_sel;
            end
            if (!st_reg.mod_word[PHADJ_BIT]) begin
               st_next.band_go = 1'b1;
               st_next.resync_go = (i_resync_mode == RESYNC_MODE_PHASE);
            end
         end else if (load_sel == SEL_MOD) begin
            st_next.mod_word = lk_reg.shift;
         end else if (load_sel == SEL_REF) begin
            st_next.ref_word = lk_reg.shift;
         end
      end

      // Unbuffered divider select follows its source at once.
      if (!st_reg.ref_word[DBUF_BIT]) begin
         st_next.outdiv_act = i_out_div_sel;
      end

      // Reference counter and optional toggle stage.
      if (hold_cnt) begin
         st_next.rcnt = 10'h000;
         st_next.tog = 1'b0;
         st_next.pfd_out = 1'b0;
      end else begin
         if (div_pulse) begin
            st_next.rcnt = 10'h000;
            st_next.tog = ~st_reg.tog;
         end else if (ref_edge) begin
            st_next.rcnt = ref_step(st_reg.rcnt);
         end
         st_next.pfd_out = st_reg.halve_act ? st_next.tog : div_pulse;
      end

      // Consecutive in-window counting; one miss starts over.
      if (st_reg.ref_word[SHDN_BIT] || st_reg.ref_word[CNTRST_BIT]) begin
         st_next.lock_cnt = 6'h00;
         st_next.lock = 1'b0;
      end else if (pfd_tick) begin
         if (!in_window) begin
            st_next.lock_cnt = 6'h00;
            st_next.lock = 1'b0;
         end else if (st_reg.lock_cnt < lock_need) begin
            st_next.lock_cnt = lock_step(st_reg.lock_cnt);
            st_next.lock = (lock_step(st_reg.lock_cnt) >= lock_need);
         end else begin
            st_next.lock = 1'b1;
         end
      end
   end

   // All system state registers here; reset loads constants only.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Field outputs.
   // ---------------------------------------------------------------
   // Frequency word fields and commit pulses.
   assign o_integer_value = st_reg.freq_word[INT_MSB:INT_LSB];
   assign o_fraction_numerator = st_reg.freq_word[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB];
   assign o_freq_commit = st_reg.commit;
   assign o_band_select_start = st_reg.band_go;
   assign o_resync_start = st_reg.resync_go;

   // Modulus word fields; modulus and phase come from active copies.
   assign o_fractional_modulus = st_reg.modulus_act;
   assign o_phase_word = st_reg.phase_act;
   assign o_prescaler_select = st_reg.mod_word[PRESC_BIT];
   assign o_phase_adjust_enable = st_reg.mod_word[PHADJ_BIT];

   // Reference word controls.
   assign o_noise_mode = st_reg.ref_word[NOISE_MSB:NOISE_LSB];
   assign o_dither_enable = (o_noise_mode == NOISE_LOW_SPUR);
   assign o_test_mux_output = st_reg.ref_word[TMUX_MSB:TMUX_LSB];
   assign o_ref_doubler = st_reg.dbl_act;
   assign o_reference_halve = st_reg.halve_act;
   assign o_ref_count = st_reg.rdiv_act;
   assign o_pump_current = st_reg.pump_act;
   assign o_pd_polarity = st_reg.ref_word[POL_BIT];
   assign o_lock_cycle_count_select = st_reg.ref_word[LCNT_BIT];
   assign o_lock_window_select = st_reg.ref_word[LWIN_BIT];
   assign o_software_shutdown = st_reg.ref_word[SHDN_BIT];

   // Shutdown overrides the individual pump and output controls.
   assign o_pump_tristate = st_reg.ref_word[PUMP3S_BIT] | st_reg.ref_word[SHDN_BIT];
   assign o_counters_held = hold_cnt;
   assign o_vco_power_down = st_reg.ref_word[SHDN_BIT];
   assign o_outputs_enable = ~st_reg.ref_word[SHDN_BIT];
   assign o_out_div_active = st_reg.outdiv_act;
   assign o_pfd_ref = st_reg.pfd_out;
   assign o_digital_lock = st_reg.lock;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   sequence s_load_mod;
      load_evt && (load_sel == SEL_MOD);
   endsequence

   sequence s_load_ref;
      load_evt && (load_sel == SEL_REF);
   endsequence

   sequence s_load_freq;
      load_evt && (load_sel == SEL_FREQ);
   endsequence

   sequence s_ref_rise;
      !st_reg.dbl_act && !hold_cnt && $rose(st_reg.ref_s2);
   endsequence

   a_mod_store: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_mod |=> (st_reg.mod_word == $past(lk_reg.shift)) && !o_freq_commit)
      else $error("modulus word not stored on select 001");

   a_ref_store: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_ref |=> o_pump_tristate == ($past(lk_reg.shift[PUMP3S_BIT])
         | $past(lk_reg.shift[SHDN_BIT])))
      else $error("reference word not stored on select 010");

   a_fraction_numerator_field: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_freq |=> o_freq_commit
         && (o_fraction_numerator == $past(lk_reg.shift[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB])))
      else $error("fraction numerator not taken from frequency word");

   a_band_skip: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_freq |=> (o_band_select_start == !o_phase_adjust_enable)
         ##1 !o_band_select_start)
      else $error("band select start wrong for phase adjust setting");

   a_buffer_wait: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_mod |=> $stable(o_fractional_modulus) && $stable(o_phase_word))
      else $error("buffered modulus changed before frequency write");

   a_buffer_apply: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_load_freq |=> o_ref_count == $past(st_reg.ref_word[RDIV_MSB:RDIV_LSB]))
      else $error("reference ratio not applied on frequency write");

   a_lock_drop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      o_software_shutdown |=> !o_digital_lock && (st_reg.rcnt == 10'h000))
      else $error("shutdown did not reset lock and counters");

   a_lock_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $rose(o_digital_lock) |-> (st_reg.lock_cnt >= $past(lock_need)))
      else $error("lock rose without the required good cycles");

   a_window_miss: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (pfd_tick && !in_window && !hold_cnt) |=> !o_digital_lock
         && (st_reg.lock_cnt == 6'h00))
      else $error("out-of-window cycle did not clear lock");

   a_counter_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      hold_cnt [*2] |-> (st_reg.rcnt == 10'h000) && !o_pfd_ref)
      else $error("reference counter ran while held");

   // Reference path checks watch internal state, so a broken divider
   // shows up here before the slower lock counter can hide it.
   a_rise_ignored: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_ref_rise |=> $stable(st_reg.rcnt) && $stable(st_reg.tog))
      else $error("rising reference edge counted with doubler off");

   a_halve_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (div_pulse && !hold_cnt && st_reg.halve_act) |=> (o_pfd_ref != $past(st_reg.tog)))
      else $error("halving stage did not toggle on divider pulse");

   a_ratio_step: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (ref_edge && !hold_cnt && !div_pulse)
         |=> (st_reg.rcnt == ref_step($past(st_reg.rcnt))))
      else $error("reference counter did not advance on active edge");

   a_dbuf_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (st_reg.ref_word[DBUF_BIT] && !load_evt) |=> $stable(o_out_div_active))
      else $error("buffered divider select moved without frequency write");

   a_commit_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      o_freq_commit |=> !o_freq_commit)
      else $error("commit pulse lasted more than one cycle");

   a_shut_outputs: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      o_software_shutdown |-> o_vco_power_down && !o_outputs_enable && o_pump_tristate)
      else $error("shutdown did not power down and disable outputs");

   a_window_pick: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (pfd_tick && !hold_cnt && o_lock_window_select && !st_reg.wnar_s2) |=> !o_digital_lock)
      else $error("narrow window miss did not clear lock");

   a_lock_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (o_digital_lock && !pfd_tick && !hold_cnt) |=> o_digital_lock)
      else $error("lock dropped without a detector cycle");

endmodule // sy_pll_regs

// >>> testbench/sy_pll_host.sv
// Host-side model that loads control words over the three-wire serial link.
`timescale 1ns/1ps
module sy_pll_host (
   // Three-wire serial link towards the block.
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_ser_le
);
   // ---------------------------------------------------------------
   // Idle link state.
   // ---------------------------------------------------------------
   // The link clock stands low between frames and load enable idles low.
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b1;
      o_ser_le = 1'b0;
   end

   // ---------------------------------------------------------------
   // Word transfer.
   // ---------------------------------------------------------------
   // Shifts a word MSB first at a 125 ns period, then latches it.
   task automatic send(input logic [31:0] word);
      o_ser_le = 1'b0;
      #41.3;
      for (int i = 31; i >= 0; i--) begin
         o_ser_data = word[i];
         #62.5 o_ser_clk = 1'b1;
         #62.5 o_ser_clk = 1'b0;
      end
      // The line has no pull, so a released bit shows its inverse, never a stale copy.
      o_ser_data = ~o_ser_data;
      #62.5 o_ser_le = 1'b1;
      // Held far beyond four system clocks with the link clock still.
      #250.0 o_ser_le = 1'b0;
      #100.0;
   endtask
endmodule // sy_pll_host

// >>> testbench/tb_synth_pll_control_registers.sv
// Self-checking bench for the synthesizer control-word block.
`timescale 1ns/1ps
module tb_synth_pll_control_registers import sy_pll_pkg::*;;
   logic i_ref_clk, i_resetn, i_ser_clk, i_ser_data, i_ser_le;
   logic i_ref_in, i_err_in_wide, i_err_in_narrow;
   logic [1:0] i_resync_mode, o_noise_mode;
   logic [2:0] i_out_div_sel, o_test_mux_output, o_out_div_active;
   logic [15:0] o_integer_value;
   logic [11:0] o_fraction_numerator, o_fractional_modulus, o_phase_word;
   logic [9:0] o_ref_count;
   logic [3:0] o_pump_current;
   logic o_freq_commit, o_band_select_start, o_resync_start, o_prescaler_select;
   logic o_phase_adjust_enable, o_dither_enable, o_ref_doubler, o_reference_halve;
   logic o_pd_polarity, o_pump_tristate, o_counters_held, o_vco_power_down;
   logic o_outputs_enable, o_lock_cycle_count_select, o_lock_window_select;
   logic o_software_shutdown, o_pfd_ref, o_digital_lock;
   int fail_count = 0;
   int check_count = 0;
   int commit_cnt = 0;
   int band_cnt = 0;
   int resync_cnt = 0;

   // ---------------------------------------------------------------
   // Design, host model and clock.
   // ---------------------------------------------------------------
   sy_pll_regs DUT (.*);
   sy_pll_host host (.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data), .o_ser_le(i_ser_le));

   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // Counting high cycles proves each pulse lasts exactly one cycle.
   always_ff @(posedge i_ref_clk) begin
      if (o_freq_commit === 1'b1) commit_cnt <= commit_cnt + 1;
      if (o_band_select_start === 1'b1) band_cnt <= band_cnt + 1;
      if (o_resync_start === 1'b1) resync_cnt <= resync_cnt + 1;
   end

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic nclk(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   task automatic wr(input logic [31:0] w);
      host.send(w);
      nclk(2);
   endtask

   // One reference period; each half is long enough for a detector tick to land.
   task automatic ref_period();
      i_ref_in = 1'b1;
      nclk(6);
      i_ref_in = 1'b0;
      nclk(6);
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_reset();
      check(o_integer_value, 0);
      check(o_fractional_modulus, 0);
      check(o_digital_lock, 0);
      check(o_outputs_enable, 1);
      check(commit_cnt, 0);
   endtask

   // Buffered fields wait for the frequency word; direct bits do not.
   task automatic t_mod();
      // The 8/9 prescaler is chosen as for a fast oscillator; unused phase is 1.
      wr({3'h0, 1'b0, 1'b1, 12'h001, 12'h019, SEL_MOD});
      check(o_prescaler_select, 1);
      check(o_phase_adjust_enable, 0);
      check(o_fractional_modulus, 0);
      check(o_phase_word, 0);
   endtask

   // Phase adjust and resync mode decide the side pulses of a commit.
   task automatic t_freq();
      logic [2:0] phadj = 3'b100;
      logic [1:0] mode [3] = '{2'h2, 2'h0, 2'h2};
      logic [1:0] expb [3] = '{2'h1, 2'h1, 2'h0};
      int c0, b0, r0;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wr({3'h0, 1'b1, 1'b1, 12'h001, 12'h019, SEL_MOD});
         i_resync_mode = mode[k];
         c0 = commit_cnt;
         b0 = band_cnt;
         r0 = resync_cnt;
         // Integer 422 respects the 8/9 minimum and fraction 13 stays below 25.
         wr({1'b0, 16'h01a6, 12'h00d, SEL_FREQ});
         check(commit_cnt - c0, 1);
         check(band_cnt - b0, expb[k][0]);
         check(resync_cnt - r0, (k == 0) ? 1 : 0);
         check(o_phase_adjust_enable, phadj[k]);
      end
      check(o_integer_value, 16'h01a6);
      check(o_fraction_numerator, 12'h00d);
      check(o_fractional_modulus, 12'h019);
      check(o_phase_word, 12'h001);
   endtask

   task automatic t_ref();
      i_out_div_sel = 3'h5;
      nclk(3);
      check(o_out_div_active, 3'h5);
      wr({1'b0, 2'h3, 3'h6, 1'b0, 1'b0, 10'h001, 1'b1, 4'ha, 6'b101011, SEL_REF});
      check(o_noise_mode, 2'h3);
      check(o_dither_enable, 1);
      check(o_test_mux_output, 3'h6);
      check(o_lock_cycle_count_select, 1);
      check(o_lock_window_select, 0);
      check(o_pd_polarity, 1);
      check(o_pump_tristate, 1);
      check(o_counters_held, 1);
      check(o_vco_power_down, 0);
      check(o_pump_current, 0);
      i_out_div_sel = 3'h2;
      nclk(3);
      check(o_out_div_active, 3'h5);
      wr({1'b0, 16'h01a6, 12'h00d, SEL_FREQ});
      check(o_out_div_active, 3'h2);
      check(o_pump_current, 4'ha);
      check(o_ref_count, 10'h001);
      wr({1'b0, 2'h0, 3'h6, 1'b0, 1'b0, 10'h001, 1'b0, 4'ha, 6'b000000, SEL_REF});
      check(o_dither_enable, 0);
      check(o_pump_tristate, 0);
      check(o_counters_held, 0);
   endtask

   // Undecoded select codes leave every field as it was.
   task automatic t_rsvd();
      int c0 = commit_cnt;
      for (int s = 3; s < 8; s++) wr({29'h1fffffff, 3'(s)});
      check(commit_cnt - c0, 0);
      check(o_test_mux_output, 3'h6);
      check(o_phase_adjust_enable, 1);
      check(o_integer_value, 16'h01a6);
   endtask

   // Counts reference periods until lock; zero means no lock in 45 periods.
   task automatic t_lock(input logic dbl, lcnt, lwin, nar, hlv, input logic [9:0] rdv,
      input int exp);
      int found = 0;
      wr({1'b0, 2'h3, 3'h0, dbl, hlv, rdv, 1'b0, 4'h7, lcnt, lwin, 4'b1000, SEL_REF});
      wr({1'b0, 16'h01a6, 12'h00d, SEL_FREQ});
      check(o_ref_doubler, dbl);
      check(o_reference_halve, hlv);
      check(o_ref_count, rdv);
      i_err_in_wide = 1'b0;
      i_err_in_narrow = 1'b0;
      repeat (2) ref_period();
      check(o_digital_lock, 0);
      i_err_in_wide = 1'b1;
      i_err_in_narrow = nar;
      for (int p = 1; p <= 45; p++) begin
         ref_period();
         if (found == 0 && o_digital_lock === 1'b1) found = p;
      end
      check(found, exp);
      check(o_pfd_ref, hlv);
   endtask

   // Shutdown drops lock and powers down while loading keeps working.
   task automatic t_shut();
      wr({1'b0, 2'h3, 3'h0, 1'b0, 1'b0, 10'h001, 1'b0, 4'h7, 6'b101100, SEL_REF});
      check(o_digital_lock, 0);
      check(o_vco_power_down, 1);
      check(o_outputs_enable, 0);
      check(o_pump_tristate, 1);
      check(o_counters_held, 1);
      check(o_software_shutdown, 1);
      check(o_lock_cycle_count_select, 1);
   endtask

   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      i_resetn = 1'b0;
      i_ref_in = 1'b0;
      i_err_in_wide = 1'b0;
      i_err_in_narrow = 1'b0;
      i_resync_mode = 2'h0;
      i_out_div_sel = 3'h0;
      nclk(3);
      i_resetn = 1'b1;
      nclk(1);
      t_reset();
      nclk(3);
      t_mod();
      t_freq();
      t_ref();
      t_rsvd();
      t_lock(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 10'h001, 0);
      t_lock(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 10'h001, 40);
      t_lock(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 10'h001, 3);
      t_lock(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 10'h001, 5);
      t_shut();
      // Leaving shutdown, a ratio of 3 and the halving stage give a tick every six periods.
      t_lock(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 10'h003, 28);
      print_verdict();
   end
endmodule // tb_synth_pll_control_registers
